/* File: floppy_read_id_track_sequencer.sv */
// Read deleted data, read identification and read whole track sequencer.
// Assumes synchronous command bytes from the host, a data separator that
// reports address fields and data bytes, and an external DMA handshake.
`timescale 1ns/1ps
`default_nettype none
module floppy_read_id_track_sequencer
  import frts_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       cmd_write,
  input  wire logic [7:0] dbp_factor,
  input  wire logic       dma_mode,
  input  wire logic       revolution_pulse_n,
  input  wire logic       hdr_valid,
  input  wire logic [7:0] hdr_track,
  input  wire logic [7:0] hdr_head,
  input  wire logic [7:0] hdr_sector,
  input  wire logic [7:0] hdr_size,
  input  wire logic       hdr_crc_err,
  input  wire logic       address_mark,
  input  wire logic       mark_deleted,
  input  wire logic       sec_byte_valid,
  input  wire logic [7:0] sec_byte,
  input  wire logic       sec_done,
  input  wire logic       sec_crc_err,
  input  wire logic       host_read,
  input  wire logic       dma_ack,
  output logic [7:0]      host_data,
  output logic            host_data_valid,
  output logic            dma_request,
  output logic            separator_enable,
  output logic            step_request,
  output logic            sector_overrun,
  output logic            busy,
  output logic            floppy_interrupt_line
);
  // ==========================================================================
  // Pin synchronisers and command decode.
  logic        rev_s1_r;
  logic        rev_s2_r;
  logic        rev_old_r;
  logic        rev_pulse;
  frts_state_e state_r;
  logic [3:0]  cmd_idx_r;
  logic [3:0]  cmd_len_r;
  logic [4:0]  op_r;
  logic        skip_r;
  logic [7:0]  want_trk_r;
  logic [7:0]  want_hd_r;
  logic [7:0]  want_sz_r;
  logic [7:0]  final_r;
  logic [7:0]  sec_cnt_r;
  logic [31:0] dly_r;
  logic [1:0]  rev_cnt_r;
  logic [7:0]  res_a_r;
  logic [7:0]  res_b_r;
  logic [7:0]  res_c_r;
  logic [7:0]  id_trk_r;
  logic [7:0]  id_hd_r;
  logic [7:0]  id_sec_r;
  logic [7:0]  id_sz_r;
  logic [2:0]  res_idx_r;
  logic        stop_after_r;
  logic        in_ready;
  logic [7:0]  f_data;
  logic        f_valid;
  logic        f_ready;
  logic        f_push;
  logic        take;
  logic [7:0]  res_byte;

  function automatic logic [3:0] frts_len(input logic [4:0] op);
    if (op == OP_READ_ID) begin
      return LEN_ID_CMD;
    end
    return LEN_RW_CMD;
  endfunction : frts_len

  function automatic logic frts_known(input logic [4:0] op);
    return (op == OP_READ_ID) || (op == OP_READ_TRACK) || (op == OP_READ_DEL);
  endfunction : frts_known

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rev_s1_r <= 1'b1;
      rev_s2_r <= 1'b1;
      rev_old_r <= 1'b1;
    end else begin
      rev_s1_r <= revolution_pulse_n;
      rev_s2_r <= rev_s1_r;
      rev_old_r <= rev_s2_r;
    end
  end
  assign rev_pulse = rev_old_r && !rev_s2_r;

  // ==========================================================================
  // Data path FIFO toward the host.
  // DMA or processor
  assign f_push = (state_r == FRTS_DATA) && sec_byte_valid;
  assign f_ready = dma_mode ? dma_ack : host_read;
  frts_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_data   (sec_byte),
    .in_valid  (f_push),
    .in_ready  (in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  always_comb begin
    unique case (res_idx_r)
      3'h0: res_byte = res_a_r;
      3'h1: res_byte = res_b_r;
      3'h2: res_byte = res_c_r;
      3'h3: res_byte = id_trk_r;
      3'h4: res_byte = id_hd_r;
      3'h5: res_byte = id_sec_r;
      default: res_byte = id_sz_r;
    endcase
  end

  // ==========================================================================
  // Command sequencer.
  assign take = (state_r == FRTS_DATA) && sec_done;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= FRTS_IDLE;
      cmd_idx_r <= '0;
      cmd_len_r <= '0;
      op_r <= '0;
      skip_r <= 1'b0;
      want_trk_r <= '0;
      want_hd_r <= '0;
      want_sz_r <= '0;
      final_r <= '0;
      sec_cnt_r <= '0;
      dly_r <= '0;
      rev_cnt_r <= '0;
      res_a_r <= '0;
      res_b_r <= '0;
      res_c_r <= '0;
      id_trk_r <= '0;
      id_hd_r <= '0;
      id_sec_r <= '0;
      id_sz_r <= '0;
      res_idx_r <= '0;
      stop_after_r <= 1'b0;
      floppy_interrupt_line <= 1'b0;
      sector_overrun <= 1'b0;
    end else begin
      unique case (state_r)
        FRTS_IDLE: begin
          if (cmd_write && frts_known(cmd_byte[OPC_MSB:OPC_LSB])) begin
            op_r <= cmd_byte[OPC_MSB:OPC_LSB];
            skip_r <= cmd_byte[BIT_SK] &&
                      (cmd_byte[OPC_MSB:OPC_LSB] == OP_READ_DEL);
            cmd_len_r <= frts_len(cmd_byte[OPC_MSB:OPC_LSB]);
            cmd_idx_r <= 4'h1;
            res_a_r <= '0;
            res_b_r <= '0;
            res_c_r <= '0;
            stop_after_r <= 1'b0;
            sector_overrun <= 1'b0;
            floppy_interrupt_line <= 1'b0;
            state_r <= FRTS_CMD;
          end
        end
        FRTS_CMD: begin
          if (cmd_write) begin
            unique case (cmd_idx_r)
              4'h1: res_a_r[BIT_HD:BIT_DS0] <= cmd_byte[BIT_HD:BIT_DS0];
              4'h2: want_trk_r <= cmd_byte;
              4'h3: want_hd_r <= cmd_byte;
              4'h5: want_sz_r <= cmd_byte;
              4'h6: final_r <= cmd_byte;
              default: ;
            endcase
            cmd_idx_r <= cmd_idx_r + 4'h1;
            if (cmd_idx_r + 4'h1 == cmd_len_r) begin
              dly_r <= 32'(dbp_factor) * 32'(DBP_UNIT_CYC);
              state_r <= FRTS_DELAY;
            end
          end
        end
        FRTS_DELAY: begin
          if (cmd_write) begin
            res_a_r[7:RA_TC_LSB] <= TC_ABNORMAL;
            state_r <= FRTS_RESULT;
          end else if (dly_r != '0) begin
            dly_r <= dly_r - 32'h1;
          end else begin
            rev_cnt_r <= '0;
            sec_cnt_r <= SECTOR_FIRST;
            state_r <= (op_r == OP_READ_TRACK) ? FRTS_WAIT_IDX : FRTS_SEARCH;
          end
        end
        FRTS_WAIT_IDX: begin
          if (cmd_write) begin
            res_a_r[7:RA_TC_LSB] <= TC_ABNORMAL;
            state_r <= FRTS_RESULT;
          end else if (rev_pulse) begin
            state_r <= FRTS_SEARCH;
          end
        end
        FRTS_SEARCH: begin
          if (rev_pulse && !address_mark) begin
            rev_cnt_r <= rev_cnt_r + 2'h1;
          end
          if (cmd_write) begin
            res_a_r[7:RA_TC_LSB] <= TC_ABNORMAL;
            state_r <= FRTS_RESULT;
          end else if (rev_pulse && !address_mark && rev_cnt_r == 2'h1) begin
            res_a_r[7:RA_TC_LSB] <= TC_ABNORMAL;
            res_b_r[RB_NO_AM] <= 1'b1;
            state_r <= FRTS_RESULT;
          end else if (hdr_valid) begin
            id_trk_r <= hdr_track;
            id_hd_r <= hdr_head;
            id_sec_r <= hdr_sector;
            id_sz_r <= hdr_size;
            if (op_r == OP_READ_ID) begin
              state_r <= FRTS_RESULT;
            end else if (op_r == OP_READ_TRACK) begin
              if (hdr_track != want_trk_r || hdr_head != want_hd_r ||
                  hdr_size != want_sz_r) begin
                res_b_r[RB_NO_DATA] <= 1'b1;
              end
              if (hdr_crc_err) begin
                res_b_r[RB_CRC] <= 1'b1;
              end
              state_r <= FRTS_DATA;
            end else if (mark_deleted) begin
              state_r <= FRTS_DATA;
            end else begin
              res_c_r[RC_CTRL_MARK] <= 1'b1;
              stop_after_r <= !skip_r;
              state_r <= skip_r ? FRTS_NEXT : FRTS_DATA;
            end
          end
        end
        FRTS_DATA: begin
          if (sec_byte_valid && !in_ready) begin
            sector_overrun <= 1'b1;
          end
          if (take) begin
            if (sec_crc_err) begin
              res_b_r[RB_CRC] <= 1'b1;
              res_c_r[RC_CRC] <= 1'b1;
              // The checksum pulse is gone by the next state, so latch it.
              if (op_r != OP_READ_TRACK) begin
                res_a_r[7:RA_TC_LSB] <= TC_ABNORMAL;
                stop_after_r <= 1'b1;
              end
            end
            state_r <= FRTS_NEXT;
          end
        end
        FRTS_NEXT: begin
          id_sec_r <= sec_cnt_r;
          if (stop_after_r || sec_cnt_r >= final_r) begin
            state_r <= FRTS_RESULT;
          end else begin
            sec_cnt_r <= sec_cnt_r + 8'h1;
            rev_cnt_r <= '0;
            state_r <= FRTS_SEARCH;
          end
        end
        FRTS_RESULT: begin
          if (!f_valid) begin
            floppy_interrupt_line <= 1'b1;
          end
          if (floppy_interrupt_line && host_read && host_data_valid) begin
            if (res_idx_r == LEN_RESULT - 3'h1) begin
              res_idx_r <= '0;
              floppy_interrupt_line <= 1'b0;
              state_r <= FRTS_IDLE;
            end else begin
              res_idx_r <= res_idx_r + 3'h1;
            end
          end
        end
        default: state_r <= FRTS_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Registered outputs.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      host_data <= '0;
      host_data_valid <= 1'b0;
      dma_request <= 1'b0;
      separator_enable <= 1'b0;
      step_request <= 1'b0;
      busy <= 1'b0;
    end else begin
      host_data_valid <= f_valid || floppy_interrupt_line;
      host_data <= f_valid ? f_data : res_byte;
      dma_request <= dma_mode && f_valid;
      separator_enable <= (state_r == FRTS_SEARCH) || (state_r == FRTS_DATA);
      step_request <= 1'b0;
      busy <= (state_r != FRTS_IDLE);
    end
  end
endmodule : floppy_read_id_track_sequencer
`default_nettype wire

/* File: frts_pkg.sv */
// Constants, command codes and result-byte fields for the read sequencer.
// Assumes an 8-bit command and result byte stream; only sector data bytes pass through the data FIFO.
package frts_pkg;
  // ==========================================================================
  // Command opcodes (low five bits of the opcode byte).
  localparam logic [4:0] OP_READ_DEL   = 5'h0c;
  localparam logic [4:0] OP_READ_ID    = 5'h0a;
  localparam logic [4:0] OP_READ_TRACK = 5'h02;
  localparam int unsigned OPC_LSB      = 0;
  localparam int unsigned OPC_MSB      = 4;
  localparam int unsigned BIT_MT       = 7;
  localparam int unsigned BIT_MFM      = 6;
  localparam int unsigned BIT_SK       = 5;
  localparam int unsigned BIT_IPS      = 7;
  localparam int unsigned BIT_HD       = 2;
  localparam int unsigned BIT_DS1      = 1;
  localparam int unsigned BIT_DS0      = 0;
  // ==========================================================================
  // Command and result lengths.
  localparam logic [3:0] LEN_ID_CMD    = 4'h2;
  localparam logic [3:0] LEN_RW_CMD    = 4'h9;
  localparam logic [2:0] LEN_RESULT    = 3'h7;
  // ==========================================================================
  // Result byte fields.
  localparam logic [1:0] TC_NORMAL     = 2'h0;
  localparam logic [1:0] TC_ABNORMAL   = 2'h1;
  localparam int unsigned RA_TC_LSB    = 6;
  localparam int unsigned RB_NO_AM     = 0;
  localparam int unsigned RB_NO_DATA   = 2;
  localparam int unsigned RB_CRC       = 5;
  localparam int unsigned RC_CRC       = 5;
  localparam int unsigned RC_CTRL_MARK = 6;
  // ==========================================================================
  // Timing: delay-before-processing unit time and its cycle count.
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned DBP_UNIT_US   = 1;
  localparam int unsigned DBP_UNIT_CYC  =
    (DBP_UNIT_US * 1000000) / CLK_PERIOD_PS;
  localparam logic [7:0] SECTOR_FIRST  = 8'h01;
  localparam int unsigned FIFO_W       = 8;
  localparam int unsigned FIFO_D       = 16;
  typedef enum logic [3:0] {
    FRTS_IDLE, FRTS_CMD, FRTS_DELAY, FRTS_WAIT_IDX, FRTS_SEARCH,
    FRTS_DATA, FRTS_NEXT, FRTS_RESULT
  } frts_state_e;
endpackage : frts_pkg

/* File: frts_fifo.sv */
// Synchronous FIFO with a combinational read of its memory.
// Assumes one clock; reads and writes follow valid and ready.
`timescale 1ns/1ps
`default_nettype none
module frts_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;
  // Read data comes straight from the memory at the read pointer, so a word waits there until popped.
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
endmodule : frts_fifo
`default_nettype wire

/* File: frts_chk_sva.sv */
// Port checker for the read sequencer, bound to its top module.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module frts_chk (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       cmd_write,
  input wire logic [7:0] dbp_factor,
  input wire logic       dma_mode,
  input wire logic       host_read,
  input wire logic [7:0] host_data,
  input wire logic       host_data_valid,
  input wire logic       dma_request,
  input wire logic       separator_enable,
  input wire logic       step_request,
  input wire logic       busy,
  input wire logic       floppy_interrupt_line
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [15:0] since_wr;
  logic [3:0]  rd_cnt;
  // Counts cycles since the last command byte and result reads.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      since_wr <= 16'h0000;
    else if (cmd_write)
      since_wr <= 16'h0000;
    else if (since_wr != 16'hffff)
      since_wr <= since_wr + 16'h0001;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      rd_cnt <= 4'h0;
    else if (!floppy_interrupt_line)
      rd_cnt <= 4'h0;
    else if (host_read)
      rd_cnt <= rd_cnt + 4'h1;
  end
  AST_DELAY: assert property (
    $rose(separator_enable) |-> since_wr >= 16'(dbp_factor) * 16'h00c8)
    else $error("separator started before the delay ran out");
  AST_NO_STEP: assert property (
    !step_request) else $error("head step requested");
  AST_SEP_BUSY: assert property (
    separator_enable |-> busy) else $error("separator on while idle");
  AST_IRQ_SEP: assert property (
    floppy_interrupt_line |-> !separator_enable)
    else $error("separator on in result phase");
  AST_IRQ_DATA: assert property (
    $rose(floppy_interrupt_line) |-> ##[0:1] host_data_valid)
    else $error("no result byte after interrupt");
  AST_RES_HOLD: assert property (
    floppy_interrupt_line && host_data_valid && !host_read
    && !$past(host_read) |=> $stable(host_data))
    else $error("result byte changed without a read");
  AST_RES_COUNT: assert property (
    $fell(floppy_interrupt_line) |-> rd_cnt == 4'h7)
    else $error("interrupt dropped at wrong result count");
  AST_DMA_MODE: assert property (
    dma_request |-> $past(dma_mode))
    else $error("transfer request outside transfer mode");
endmodule : frts_chk
bind floppy_read_id_track_sequencer frts_chk frts_chk_i (
  .mclk, .resetn, .cmd_write, .dbp_factor, .dma_mode, .host_read,
  .host_data, .host_data_valid, .dma_request, .separator_enable,
  .step_request, .busy, .floppy_interrupt_line);
`default_nettype wire

/* File: frts_host_model.sv */
// Host and transfer-controller model that drains the sequencer's bytes.
// Assumes a byte is offered at a time and updates a cycle after a read.
`timescale 1ns/1ps
`default_nettype none
module frts_host_model (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       dma_mode,
  input  wire logic [7:0] host_data,
  input  wire logic       host_data_valid,
  input  wire logic       dma_request,
  input  wire logic       floppy_interrupt_line,
  input  wire logic       slow,
  output var  logic       host_read,
  output var  logic       dma_ack
);
  logic [7:0] got[$];
  logic [1:0] gap_r;
  logic       take;
  assign take = host_data_valid && !slow && gap_r == 2'h0
                && (!dma_mode || floppy_interrupt_line || dma_request);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      host_read <= 1'b0;
      dma_ack <= 1'b0;
      gap_r <= 2'h0;
    end else begin
      host_read <= take && (floppy_interrupt_line || !dma_mode);
      dma_ack <= take && dma_mode && !floppy_interrupt_line;
      gap_r <= take ? 2'h2 : (gap_r == 2'h0 ? 2'h0 : gap_r - 2'h1);
      if (take)
        got.push_back(host_data);
    end
  end
endmodule : frts_host_model
`default_nettype wire

/* File: tb_top.sv */
// Testbench for the read sequencer; the bench plays drive and separator.
// Assumes the host model drains data and result bytes.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       mclk = 1'b0, resetn = 1'b0, cmd_write = 1'b0;
  logic       dma_mode = 1'b0, revolution_pulse_n = 1'b1, slow = 1'b0;
  logic       hdr_valid = 1'b0, hdr_crc_err = 1'b0, address_mark = 1'b0;
  logic       mark_deleted = 1'b0, sec_byte_valid = 1'b0;
  logic       sec_done = 1'b0, sec_crc_err = 1'b0;
  logic [7:0] cmd_byte = 8'h00, dbp_factor = 8'h00, sec_byte = 8'h00;
  logic [7:0] hdr_track = 8'h00, hdr_head = 8'h00;
  logic [7:0] hdr_sector = 8'h00, hdr_size = 8'h00;
  logic       host_read, dma_ack, host_data_valid, dma_request, busy;
  logic       separator_enable, step_request, sector_overrun;
  logic       floppy_interrupt_line;
  logic [7:0] host_data;
  logic [7:0] exp_q[$];
  logic [7:0] r[7];
  int         failures = 0;
  int         n_tests = 0;
  floppy_read_id_track_sequencer floppy_read_id_track_sequencer_i (
    .mclk, .resetn, .cmd_byte, .cmd_write, .dbp_factor, .dma_mode,
    .revolution_pulse_n, .hdr_valid, .hdr_track, .hdr_head, .hdr_sector,
    .hdr_size, .hdr_crc_err, .address_mark, .mark_deleted,
    .sec_byte_valid, .sec_byte, .sec_done, .sec_crc_err, .host_read,
    .dma_ack, .host_data, .host_data_valid, .dma_request,
    .separator_enable, .step_request, .sector_overrun, .busy,
    .floppy_interrupt_line);
  frts_host_model frts_host_model_i (
    .mclk, .resetn, .dma_mode, .host_data, .host_data_valid,
    .dma_request, .floppy_interrupt_line, .slow, .host_read, .dma_ack);
  always #2.5 mclk = ~mclk;
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp1(input logic g, input logic e);
    cmp({7'h00, g}, {7'h00, e});
  endtask : cmp1
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic wr(input logic [7:0] b);
    @(posedge mclk);
    cmd_byte <= b;
    cmd_write <= 1'b1;
    @(posedge mclk);
    cmd_write <= 1'b0;
  endtask : wr
  task automatic cmds(input logic [7:0] b[$]);
    frts_host_model_i.got.delete();
    exp_q.delete();
    foreach (b[i]) wr(b[i]);
  endtask : cmds
  task automatic hdr(input logic [7:0] t, h, s, z, input logic ce, dl);
    @(posedge mclk);
    {hdr_valid, address_mark} <= 2'h3;
    {hdr_track, hdr_head, hdr_sector, hdr_size} <= {t, h, s, z};
    {hdr_crc_err, mark_deleted} <= {ce, dl};
    @(posedge mclk);
    {hdr_valid, address_mark} <= 2'h0;
  endtask : hdr
  task automatic sec(input int n, input logic [7:0] b, input logic ce,
                     input logic keep);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      sec_byte_valid <= 1'b1;
      sec_byte <= b + i[7:0];
      if (keep)
        exp_q.push_back(b + i[7:0]);
    end
    @(posedge mclk);
    {sec_byte_valid, sec_done, sec_crc_err} <= {2'h1, ce};
    @(posedge mclk);
    {sec_done, sec_crc_err} <= 2'h0;
  endtask : sec
  task automatic rev;
    @(posedge mclk);
    revolution_pulse_n <= 1'b0;
    cyc(2);
    revolution_pulse_n <= 1'b1;
    cyc(6);
  endtask : rev
  // Waits out the result phase, then checks data bytes in order.
  task automatic results(input string name);
    int k;
    int n;
    k = 0;
    while (floppy_interrupt_line !== 1'b1 && k < 20000) begin
      @(posedge mclk);
      k++;
    end
    while (floppy_interrupt_line !== 1'b0 && k < 20000) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 20000) begin
      failures++;
      complete_run();
    end
    #1;
    n = frts_host_model_i.got.size();
    for (int i = 0; i < 7; i++) r[i] = frts_host_model_i.got[n - 7 + i];
    cmp(8'(n - 7), 8'(exp_q.size()));
    foreach (exp_q[i]) cmp(frts_host_model_i.got[i], exp_q[i]);
    $display("test %s done", name);
  endtask : results
  task automatic t_readid;
    dbp_factor <= 8'h01;
    cmds('{8'h4a, 8'h05});
    // motor is taken as on while the delay runs.
    cyc(150);
    #1 cmp1(separator_enable, 1'b0);
    cyc(70);
    #1 cmp1(separator_enable, 1'b1);
    hdr(8'h10, 8'h01, 8'h07, 8'h02, 1'b0, 1'b0);
    results("readid");
    cmp(r[0], 8'h05);
    cmp(r[1] | r[2], 8'h00);
    cmp(r[3] ^ r[5], 8'h17);
    cmp(r[4] + r[6], 8'h03);
  endtask : t_readid
  task automatic t_id_err(input logic by_write);
    dbp_factor <= 8'h00;
    cmds('{8'h0a, 8'h00});
    cyc(10);
    if (by_write)
      wr(8'h00);
    else
      repeat (2) rev();
    results(by_write ? "idabort" : "nomark");
    cmp(r[0] & 8'hc0, 8'h40);
    cmp(r[1] & 8'h01, {7'h00, !by_write});
  endtask : t_id_err
  task automatic t_track(input logic abort);
    dma_mode <= 1'b1;
    cmds('{8'h42, 8'h01, 8'h20, 8'h00, 8'h01, 8'h02, 8'h03, 8'h1b,
           8'hff});
    hdr(8'h20, 8'h00, 8'h01, 8'h02, 1'b0, 1'b0);
    sec(4, 8'h80, 1'b0, 1'b0);
    #1 cmp1(separator_enable, 1'b0);
    if (abort) begin
      wr(8'h00);
      results("trackabort");
      cmp(r[0] & 8'hc0, 8'h40);
    end else begin
      slow <= 1'b1;
      rev();
      hdr(8'h20, 8'h00, 8'h05, 8'h02, 1'b0, 1'b0);
      sec(16, 8'h10, 1'b0, 1'b1);
      #1 cmp1(dma_request, 1'b1);
      cmp1(sector_overrun, 1'b0);
      slow <= 1'b0;
      cyc(60);
      hdr(8'h21, 8'h00, 8'h06, 8'h02, 1'b0, 1'b0);
      sec(4, 8'h30, 1'b1, 1'b1);
      cyc(20);
      hdr(8'h20, 8'h00, 8'h09, 8'h02, 1'b1, 1'b0);
      sec(4, 8'h40, 1'b0, 1'b1);
      results("track");
      cmp(r[1] & 8'h24, 8'h24);
      cmp(r[2] & 8'h20, 8'h20);
      cmp(r[5], 8'h03);
    end
  endtask : t_track
  task automatic t_del(input logic sk, d0, more, c6, input logic [7:0] final_sector_index);
    dma_mode <= 1'b0;
    cmds('{{2'h1, sk, 5'h0c}, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, final_sector_index,
           8'h1b, 8'hff});
    hdr(8'h00, 8'h00, 8'h01, 8'h02, 1'b0, d0);
    sec(6, 8'h50, 1'b0, !(sk && !d0));
    if (more) begin
      hdr(8'h00, 8'h00, 8'h02, 8'h02, 1'b0, 1'b1);
      sec(6, 8'h60, 1'b0, 1'b1);
    end
    results("deleted");
    cmp(r[2] & 8'h40, {1'b0, c6, 6'h00});
  endtask : t_del
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    t_readid();
    t_id_err(1'b1);
    t_id_err(1'b0);
    t_track(1'b1);
    t_track(1'b0);
    t_del(1'b0, 1'b0, 1'b0, 1'b1, 8'h02);
    t_del(1'b0, 1'b1, 1'b0, 1'b0, 8'h01);
    t_del(1'b1, 1'b0, 1'b1, 1'b1, 8'h02);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
